// File: core/awm_top.sv
// application warning mask with AHB-Lite registers and source selectors
// assumes all monitor inputs synchronous to mclk
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module awm_top
  import awm_pkg::*;
#(
  parameter int NSEL = 4
)(
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [NWARN-1:0] warn_in,
  input  wire logic             fault_event,
  input  wire logic             safety_enable_a,
  input  wire logic             safety_enable_b,
  input  wire logic [4:0]       general_in,
  input  wire logic             multifunction_input,
  input  wire logic             gen_warn_critical,
  input  wire logic             timer1_out,
  input  wire logic             timer2_out,
  input  wire logic             init_done,
  input  wire logic             start_cmd,
  input  wire logic             freq_available,
  input  wire logic             op_fault,
  input  wire logic             freq_reached,
  input  wire logic             stator_above_set,
  input  wire logic             overload,
  input  wire logic             heatsink_warn,
  input  wire logic             inside_warn,
  output logic                  app_warning,
  output logic                  app_warning_dout,
  output logic                  safe_torque_off,
  output logic [NSEL-1:0]       func_in
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NWARN-1:0]       mask;
    logic [NWARN-1:0]       fault_cap;
    logic [4:0]             remote_en;
    logic [4:0]             remote_val;
    logic                   mfi_remote_en;
    logic                   mfi_remote_val;
    logic [1:0]             mfi_mode;
    logic [NSEL-1:0][CODE_W-1:0] sel;
    logic [22:0]            flags;
    logic                   warn;
    logic                   stoff;
    logic [NSEL-1:0]        fin;
    logic                   dph;
    logic                   dwr;
    logic [7:0]             daddr;
    logic [31:0]            rdata;
  } awm_state_type;

  awm_state_type st;
  awm_state_type next_st;
  logic [NSEL-1:0] mux_out;
  logic [4:0]      gin_eff;

  function automatic logic [7:0] sel_addr(input int i);
    sel_addr = 8'(A_SEL0 + 4 * i);
  endfunction

  assign gin_eff = (st.remote_en & st.remote_val) | (~st.remote_en & general_in);

  // ------------------------------------------------------------
  // source selectors
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : g_sel
      awm_source_mux u_mux (
        .code  (st.sel[g]),
        .gin   (gin_eff),
        .flags (st.flags),
        .sel   (mux_out[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [CMD_W-1:0] cmd;
    logic             wr;
    logic             take;
    cmd = hwdata[CMD_W-1:0];
    take = hsel && hready && htrans == HTRANS_NONSEQ;
    next_st = st;
    wr = st.dph && st.dwr;
    // mask command is a read-modify-write in one cycle
    if (wr && st.daddr == A_CMD) begin
      if (cmd == CMD_ALL) begin
        next_st.mask = MASK_ALL;
      end else if (cmd == CMD_CLR_ALL) begin
        next_st.mask = MASK_RESET;
      end else if (cmd >= CMD_SET_LO && cmd < CMD_SET_LO + CMD_W'(NWARN)) begin
        // bit index is command minus 10
        next_st.mask[4'(cmd - CMD_SET_LO)] = 1'b1;
      end else if (cmd >= CMD_CLR_LO && cmd < CMD_CLR_LO + CMD_W'(NWARN)) begin
        next_st.mask[4'(cmd - CMD_CLR_LO)] = 1'b0;
      end
    end else if (wr && st.daddr == A_CTRL) begin
      next_st.remote_en      = hwdata[4:0];
      next_st.remote_val     = hwdata[12:8];
      next_st.mfi_remote_en  = hwdata[16];
      next_st.mfi_remote_val = hwdata[17];
      next_st.mfi_mode       = hwdata[25:24];
    end
    for (int i = 0; i < NSEL; i++) begin
      if (wr && st.daddr == sel_addr(i)) begin
        next_st.sel[i] = hwdata[CODE_W-1:0];
      end
    end
    if (fault_event) begin
      next_st.fault_cap = warn_in;
    end
    // combined warning, one cycle after the mask changes
    next_st.warn = |(st.mask & warn_in);
    // drive release follows both safety enables
    next_st.stoff = ~(safety_enable_a & safety_enable_b);
    next_st.flags = '0;
    next_st.flags[0] = safety_enable_a & safety_enable_b;
    // only in digital mode, or remote
    next_st.flags[1] = st.mfi_remote_en ? st.mfi_remote_val :
                       (st.mfi_mode == MFI_MODE_DIG) & multifunction_input;
    next_st.flags[2] = gen_warn_critical;
    next_st.flags[3] = timer1_out;
    next_st.flags[4] = timer2_out;
    next_st.flags[5] = init_done;
    next_st.flags[6] = safety_enable_a & safety_enable_b & start_cmd & freq_available;
    next_st.flags[7] = op_fault;
    next_st.flags[8] = freq_reached;
    next_st.flags[9] = stator_above_set;
    next_st.flags[10] = overload;
    next_st.flags[11] = heatsink_warn;
    next_st.flags[12] = inside_warn;
    next_st.flags[13] = st.warn;
    next_st.fin = mux_out;
    // ------------------------------------------------------------
    // bus slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    if (hready) begin
      next_st.dph   = take;
      next_st.dwr   = hwrite;
      next_st.daddr = haddr[7:0];
    end
    next_st.rdata = '0;
    if (take && !hwrite) begin
      if (haddr[7:0] == A_MASK) begin
        next_st.rdata = REG_W'(st.mask);
      end else if (haddr[7:0] == A_DISPLAY) begin
        next_st.rdata = REG_W'(warn_in);
      end else if (haddr[7:0] == A_FAULT) begin
        next_st.rdata = REG_W'(st.fault_cap);
      end else if (haddr[7:0] == A_CTRL) begin
        next_st.rdata = {6'h00, st.mfi_mode, 6'h00, st.mfi_remote_val, st.mfi_remote_en,
                         3'h0, st.remote_val, 3'h0, st.remote_en};
      end else if (haddr[7:0] == A_STATUS) begin
        next_st.rdata = REG_W'({st.fin, st.stoff, st.warn, st.flags}) & 32'h0FFFFFFF;
      end else begin
        for (int i = 0; i < NSEL; i++) begin
          if (haddr[7:0] == sel_addr(i)) begin
            next_st.rdata = REG_W'(st.sel[i]);
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.stoff <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata           = st.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign app_warning      = st.warn;
  assign app_warning_dout = st.warn;
  assign safe_torque_off  = st.stoff;
  assign func_in          = st.fin;
endmodule

// File: common/awm_pkg.sv
// package for the application warning mask and signal source selector
// assumes one 50 MHz clock and command strobes synchronous to it
// Functional notes
// - mask code reads as the sum of every enabled warning bit
// - activate-all command (2) sets mask code 003F
// - belt 0001 (cmd 10), soft limits 0002 and 0004
// - hard limit positive 0008 (cmd 13), negative 0010 (cmd 14)
// - contouring warning bit 0020, enabled by command 15
// - encoder 0040 (16), user one 0080 (17), user two 0100 (18)
// - combined warning high while any enabled warning active; code 215 selects it, code 27 is not decoded and reads 0
// - warnings display shows all active warnings regardless of mask
// - on a fault, capture active warnings into status regardless of mask
// - function inputs pick source by code; 6 on, 7 off
// - code 70 is drive release from both safety enables, tied to safe torque off
// - codes 71 to 75 are general inputs 2 to 6, or remote operation
// - code 76 is multifunction input only in mode 3, or remote operation
// - code 157 follows the general warning mask flag
// - codes 158 and 159 are timer one and timer two outputs
// - code 160 asserted once initialised and ready
// - code 161 needs both safety enables, start command and output frequency
// - code 162 asserted on an operational fault
// - code 163 asserted once output frequency reaches reference
// - code 164 while stator frequency exceeds setting threshold
// - code 165 on an overload monitor report
// - code 166 heat sink, code 167 inside temperature warning reached
// - command 102 clears all mask bits; command 0 changes nothing
// - commands 110 to 118 clear the one bit of command minus 110
package awm_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int NWARN    = 9;
  localparam int CODE_W   = 9;
  localparam int CMD_W    = 7;
  localparam int REG_W    = 32;
  // ------------------------------------------------------------
  // mask commands
  // ------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_NONE    = 7'h00;
  localparam logic [CMD_W-1:0] CMD_ALL     = 7'h02;
  localparam logic [CMD_W-1:0] CMD_SET_LO  = 7'h0A;
  localparam logic [CMD_W-1:0] CMD_CLR_ALL = 7'h66;
  localparam logic [CMD_W-1:0] CMD_CLR_LO  = 7'h6E;
  localparam logic [NWARN-1:0] MASK_ALL    = 9'h03F;
  localparam logic [NWARN-1:0] MASK_RESET  = 9'h000;
  // warning bit positions
  localparam int W_BELT = 0;
  localparam int W_SLP  = 1;
  localparam int W_SLN  = 2;
  localparam int W_HLP  = 3;
  localparam int W_HLN  = 4;
  localparam int W_CONTOURING_WARNING = 5;
  localparam int W_ENC  = 6;
  localparam int W_USR1 = 7;
  localparam int W_USR2 = 8;
  // ------------------------------------------------------------
  // source codes
  // ------------------------------------------------------------
  localparam logic [CODE_W-1:0] SRC_ON      = 9'h006;
  localparam logic [CODE_W-1:0] SRC_OFF     = 9'h007;
  localparam logic [CODE_W-1:0] SRC_RELEASE = 9'h046;
  localparam logic [CODE_W-1:0] SRC_GIN_LO  = 9'h047;
  localparam logic [CODE_W-1:0] SRC_GIN_HI  = 9'h04B;
  localparam logic [CODE_W-1:0] SRC_MFI     = 9'h04C;
  localparam logic [CODE_W-1:0] SRC_GENWARN = 9'h09D;
  localparam logic [CODE_W-1:0] SRC_TIMER1  = 9'h09E;
  localparam logic [CODE_W-1:0] SRC_TIMER2  = 9'h09F;
  localparam logic [CODE_W-1:0] SRC_READY   = 9'h0A0;
  localparam logic [CODE_W-1:0] SRC_RUN     = 9'h0A1;
  localparam logic [CODE_W-1:0] SRC_ERROR   = 9'h0A2;
  localparam logic [CODE_W-1:0] SRC_FREQREF = 9'h0A3;
  localparam logic [CODE_W-1:0] SRC_SETFREQ = 9'h0A4;
  localparam logic [CODE_W-1:0] SRC_IXT     = 9'h0A5;
  localparam logic [CODE_W-1:0] SRC_HEATSNK = 9'h0A6;
  localparam logic [CODE_W-1:0] SRC_INSIDE  = 9'h0A7;
  localparam logic [CODE_W-1:0] SRC_APPWARN = 9'h0D7;
  localparam logic [CODE_W-1:0] SRC_APPWDO  = 9'h01B;
  localparam logic [1:0]        MFI_MODE_DIG = 2'h3;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] A_CMD     = 8'h00;
  localparam logic [7:0] A_MASK    = 8'h04;
  localparam logic [7:0] A_DISPLAY = 8'h08;
  localparam logic [7:0] A_FAULT   = 8'h0C;
  localparam logic [7:0] A_CTRL    = 8'h10;
  localparam logic [7:0] A_SEL0    = 8'h20;
  localparam logic [7:0] A_STATUS  = 8'h40;
  localparam logic [7:0] A_SRC_MSK = 8'hE0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// File: core/awm_source_mux.sv
// one function input source selector
// assumes the flag vector is already registered by the parent
`timescale 1ns/1ps
module awm_source_mux
  import awm_pkg::*;
(
  input  wire logic [CODE_W-1:0] code,
  input  wire logic [4:0]        gin,
  input  wire logic [22:0]       flags,
  output logic                   sel
);
  // flags: 0 release,1 mfi,2 genwarn,3 t1,4 t2,5 ready,6 run,7 error,
  // 8 freqref,9 setfreq,10 ixt,11 heatsink,12 inside,13 appwarn
  always_comb begin
    if (code == SRC_ON) begin
      sel = 1'b1;
    end else if (code == SRC_OFF) begin
      sel = 1'b0;
    end else if (code == SRC_RELEASE) begin
      sel = flags[0];
    end else if (code >= SRC_GIN_LO && code <= SRC_GIN_HI) begin
      sel = gin[3'(code - SRC_GIN_LO)];
    end else if (code == SRC_MFI) begin
      sel = flags[1];
    end else if (code == SRC_GENWARN) begin
      sel = flags[2];
    end else if (code == SRC_TIMER1) begin
      sel = flags[3];
    end else if (code == SRC_TIMER2) begin
      sel = flags[4];
    end else if (code == SRC_READY) begin
      sel = flags[5];
    end else if (code == SRC_RUN) begin
      sel = flags[6];
    end else if (code == SRC_ERROR) begin
      sel = flags[7];
    end else if (code == SRC_FREQREF) begin
      sel = flags[8];
    end else if (code == SRC_SETFREQ) begin
      sel = flags[9];
    end else if (code == SRC_IXT) begin
      sel = flags[10];
    end else if (code == SRC_HEATSNK) begin
      sel = flags[11];
    end else if (code == SRC_INSIDE) begin
      sel = flags[12];
    end else if (code == SRC_APPWARN) begin
      sel = flags[13];
    end else begin
      sel = 1'b0;
    end
  end
endmodule

// File: bench/awm_monitor.sv
// checker on the ports of the warning mask block
// assumes a zero-wait bus slave and registered outputs on mclk
`timescale 1ns/1ps
module awm_monitor
  import awm_pkg::*;
(
  input wire logic             mclk,
  input wire logic             arst_n,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [NWARN-1:0] warn_in,
  input wire logic             safety_enable_a,
  input wire logic             safety_enable_b,
  input wire logic             app_warning,
  input wire logic             app_warning_dout,
  input wire logic             safe_torque_off
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic rd_req;
  assign rd_req = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;

  AST_DOUT_FOLLOWS: assert property (
    app_warning_dout == app_warning) else $error("warning pins differ");
  AST_NO_CAUSE_QUIET: assert property (
    warn_in == '0 |=> !app_warning) else $error("warning without active input");
  AST_RISE_HAS_CAUSE: assert property (
    $rose(app_warning) |-> $past(warn_in) != '0) else $error("warning rose with no cause");
  // the edge that lifts reset still loads reset values, so it starts no attempt
  AST_STO_RELEASED: assert property (
    arst_n && safety_enable_a && safety_enable_b |=> !safe_torque_off)
    else $error("stop not released");
  AST_STO_HELD: assert property (
    !(safety_enable_a && safety_enable_b) |=> safe_torque_off) else $error("stop not held");
  AST_DISPLAY_READ: assert property (
    rd_req && haddr[7:0] == A_DISPLAY |=> hrdata == {23'h0, $past(warn_in)})
    else $error("display read differs from live warnings");
  AST_MASK_WIDTH: assert property (
    rd_req && haddr[7:0] == A_MASK |=> hrdata[31:9] == '0) else $error("mask code too wide");
  AST_BUS_OKAY: assert property (
    hreadyout && !hresp) else $error("bus slave stalled or erred");
endmodule
bind awm_top awm_monitor i_awm_monitor (
  .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .warn_in(warn_in), .safety_enable_a(safety_enable_a),
  .safety_enable_b(safety_enable_b), .app_warning(app_warning),
  .app_warning_dout(app_warning_dout), .safe_torque_off(safe_torque_off));

// File: bench/awm_consumer.sv
// consumer model of the selected signals and the warning output
// assumes the block's outputs are registered on mclk
`timescale 1ns/1ps
module awm_consumer (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [3:0] func_in,
  input  wire logic       app_warning_dout,
  output logic      [7:0] warn_events
);
  // ----------------------------------------
  // count warning edges, as a lamp driver would
  // ----------------------------------------
  logic seen_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q      <= 1'b0;
      warn_events <= 8'h00;
    end else begin
      seen_q <= app_warning_dout;
      if (app_warning_dout && !seen_q) warn_events <= warn_events + 8'h01;
    end
  end
endmodule

// File: bench/app_warning_mask_signal_select_test.sv
// testbench for the warning mask and the source selectors
// assumes zero-wait bus answers and the register map of the hand-over
`timescale 1ns/1ps
module app_warning_mask_signal_select_test;
  import awm_pkg::*;
  logic             mclk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic             fault_event = 1'b0, safety_enable_a = 1'b1, safety_enable_b = 1'b1;
  logic             multifunction_input = 1'b0, hreadyout, hresp, app_warning;
  logic             app_warning_dout, safe_torque_off;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]       htrans = 2'h0;
  logic [2:0]       hsize = 3'h2;
  logic [NWARN-1:0] warn_in = 9'h000;
  logic [4:0]       general_in = 5'h0D;
  logic [11:0]      fl = 12'h000;
  logic [3:0]       func_in;
  logic [7:0]       warn_events;
  int               mismatches = 0;
  int               check_count = 0;

  always #10 mclk = ~mclk;

  awm_top #(.NSEL(4)) i_awm_top (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .warn_in(warn_in), .fault_event(fault_event),
    .safety_enable_a(safety_enable_a), .safety_enable_b(safety_enable_b),
    .general_in(general_in), .multifunction_input(multifunction_input),
    .gen_warn_critical(fl[0]), .timer1_out(fl[1]), .timer2_out(fl[2]), .init_done(fl[3]),
    .start_cmd(fl[4]), .op_fault(fl[5]), .freq_reached(fl[6]), .stator_above_set(fl[7]),
    .overload(fl[8]), .heatsink_warn(fl[9]), .inside_warn(fl[10]), .freq_available(fl[11]),
    .app_warning(app_warning), .app_warning_dout(app_warning_dout),
    .safe_torque_off(safe_torque_off), .func_in(func_in));

  awm_consumer i_awm_consumer (.mclk(mclk), .arst_n(arst_n), .func_in(func_in),
    .app_warning_dout(app_warning_dout), .warn_events(warn_events));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic src(input int code, input logic e);
    bus(1'b1, A_SEL0, 32'(code), r);
    cyc(4);
    check("func_in", {31'h0, func_in[0]}, {31'h0, e});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mask;
    logic [31:0] m;
    m = 32'h0;
    for (int c = 10; c <= 18; c++) begin
      m = m | (32'h1 << (c - 10));
      bus(1'b1, A_CMD, 32'(c), r);
      bus(1'b0, A_MASK, 32'h0, r);
      check("mask set", r, m);
    end
    for (int c = 110; c <= 118; c++) begin
      m = m & ~(32'h1 << (c - 110));
      bus(1'b1, A_CMD, 32'(c), r);
      bus(1'b0, A_MASK, 32'h0, r);
      check("mask clear", r, m);
    end
    bus(1'b1, A_CMD, {25'h0, CMD_ALL}, r);
    bus(1'b0, A_MASK, 32'h0, r);
    check("mask all", r, 32'h0000_003F);
    bus(1'b1, A_CMD, {25'h0, CMD_NONE}, r);
    bus(1'b0, A_MASK, 32'h0, r);
    check("mask keep", r, 32'h0000_003F);
    bus(1'b1, A_CMD, {25'h0, CMD_CLR_ALL}, r);
    bus(1'b0, A_MASK, 32'h0, r);
    check("mask none", r, 32'h0);
    $display("mask command test done");
  endtask

  task automatic t_warn;
    bus(1'b1, A_CMD, 32'd15, r);
    warn_in <= 9'h020;
    cyc(3);
    check("app_warning", {31'h0, app_warning}, 32'h1);
    check("warn_events", {24'h0, warn_events}, 32'h1);
    warn_in <= 9'h040;
    cyc(3);
    check("app_warning masked", {31'h0, app_warning}, 32'h0);
    bus(1'b0, A_DISPLAY, 32'h0, r);
    check("display", r, 32'h40);
    fault_event <= 1'b1;
    cyc(1);
    fault_event <= 1'b0;
    warn_in     <= 9'h020;
    cyc(3);
    bus(1'b0, A_FAULT, 32'h0, r);
    check("fault capture", r, 32'h40);
    bus(1'b1, A_CMD, 32'd115, r);
    cyc(2);
    check("warning after clear", {31'h0, app_warning}, 32'h0);
    warn_in <= 9'h000;
    $display("warning output test done");
  endtask

  task automatic t_src;
    logic e;
    src(6, 1'b1);
    src(7, 1'b0);
    src(70, 1'b1);
    for (int k = 0; k < 5; k++) src(71 + k, general_in[k]);
    bus(1'b1, A_CTRL, 32'h0000_0001, r);
    src(71, 1'b0);
    bus(1'b1, A_CTRL, 32'h0300_0000, r);
    multifunction_input <= 1'b1;
    src(76, 1'b1);
    bus(1'b1, A_CTRL, 32'h0, r);
    src(76, 1'b0);
    // remote operation wins over a pin that is not in digital mode
    bus(1'b1, A_CTRL, 32'h0003_0000, r);
    src(76, 1'b1);
    bus(1'b1, A_CTRL, 32'h0, r);
    for (int p = 0; p < 2; p++) begin
      fl <= p ? 12'h5A5 : 12'hA5A;
      cyc(1);
      for (int k = 0; k <= 10; k++) begin
        e = (k == 4) ? fl[4] & fl[11] : fl[k];
        src(157 + k, e);
      end
    end
    src(200, 1'b0);
    bus(1'b1, A_CMD, 32'd16, r);
    warn_in <= 9'h040;
    src(215, 1'b1);
    check("app_warning_dout", {31'h0, app_warning_dout}, 32'h1);
    warn_in <= 9'h000;
    bus(1'b1, A_SEL0 + 8'h04, 32'd6, r);
    bus(1'b1, A_SEL0 + 8'h08, 32'd7, r);
    bus(1'b1, A_SEL0 + 8'h0C, 32'd6, r);
    cyc(4);
    check("func_in 3 to 1", {29'h0, func_in[3:1]}, 32'h5);
    safety_enable_b <= 1'b0;
    src(70, 1'b0);
    check("safe_torque_off", {31'h0, safe_torque_off}, 32'h1);
    $display("source select test done");
  endtask

  initial begin
    cyc(20);
    arst_n <= 1'b1;
    cyc(1);
    t_mask();
    t_warn();
    t_src();
    complete_run();
  end

  // hang guard: the tests take a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule
